// >>> core/asp_pkg.sv
// shared constants and types of the asynchronous serial port
package asp_pkg;
  // register addresses
  localparam logic [15:0] MODE_ADDR = 16'hff90;
  localparam logic [15:0] RXBUF_ADDR = 16'hff92;
  localparam logic [15:0] ERR_ADDR = 16'hff94;
  localparam logic [15:0] TXST_ADDR = 16'hff95;
  localparam logic [15:0] TXBUF_ADDR = 16'hff96;
  // serial_mode_control fields
  localparam int MODE_CLK_EN = 7;
  localparam int MODE_TX_EN = 6;
  localparam int MODE_RX_EN = 5;
  localparam int MODE_PAR_HI = 4;
  localparam int MODE_PAR_LO = 3;
  localparam int MODE_CHAR_LEN = 2;
  localparam int MODE_STOP_SEL = 1;
  localparam int MODE_ERR_SEL = 0;
  // receive_error_status fields
  localparam int ERR_MP_ID = 3;
  localparam int ERR_PARITY = 2;
  localparam int ERR_FRAME = 1;
  localparam int ERR_OVERRUN = 0;
  // transmit_status fields
  localparam int TXST_BUF_FULL = 1;
  localparam int TXST_SHIFTING = 0;
  // reset values
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] TXBUF_RST = 8'hff;
  localparam logic [7:0] RXBUF_RST = 8'hff;
  localparam logic [7:0] SHIFT_IDLE = 8'hff;
  localparam logic [7:0] ERR_RST = 8'h00;
  // timing, in port clock ticks (16x the bit rate); the divider default is in clk cycles
  localparam int OVS = 16;
  localparam int SAMPLE_MID = 8;
  localparam int IRDA_PULSE = 3;
  localparam int SETTLE_TICKS = 2;
  localparam int BAUD_DIV_DEF = 27;

  typedef enum logic [1:0] {
    PAR_NONE = 2'h0,
    PAR_ZERO = 2'h1,
    PAR_ODD = 2'h2,
    PAR_EVEN = 2'h3
  } asp_par_t;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_START = 5'h02,
    ST_DATA = 5'h04,
    ST_EXTRA = 5'h08,
    ST_STOP = 5'h10
  } asp_state_t;
endpackage : asp_pkg

// >>> core/asp_baud.sv
// port clock divider: one-cycle tick at 16x the bit rate
`timescale 1ns/1ps
`default_nettype none
module asp_baud #(
  parameter int DIV = asp_pkg::BAUD_DIV_DEF
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic run,
  output logic tick
);
  localparam int CW = $clog2(DIV + 1);

  if (DIV < 1) begin : g_chk
    $error("asp_baud: DIV must be at least 1");
  end

  logic [CW-1:0] cnt_reg;

  // stopped divider is the clock gate of the port
  always_ff @(posedge clk) begin
    if (rst || !run) begin
      cnt_reg <= '0;
      tick <= 1'b0;
    end else if (cnt_reg == CW'(DIV - 1)) begin
      cnt_reg <= '0;
      tick <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + CW'(1);
      tick <= 1'b0;
    end
  end
endmodule : asp_baud
`default_nettype wire

// >>> core/asp_tx.sv
// transmit shifter and framing controller
`timescale 1ns/1ps
`default_nettype none
module asp_tx #(
  parameter int OVS = asp_pkg::OVS
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic clr,
  input wire logic tick,
  input wire logic load,
  input wire logic [7:0] data,
  input wire logic eight_bit,
  input wire logic [1:0] par_sel,
  input wire logic two_stop,
  input wire logic mp_mode,
  input wire logic mp_bit,
  input wire logic irda,
  output logic line,
  output logic busy,
  output logic done
);
  if (OVS < 4 || OVS > 16) begin : g_chk
    $error("asp_tx: OVS must be 4 to 16");
  end

  asp_pkg::asp_state_t state_reg;
  logic [7:0] shift_reg;
  logic [3:0] sub_reg;
  logic [2:0] idx_reg;
  logic extra_reg;
  logic stop2_reg;
  logic cur_bit;
  logic step;
  logic has_extra;
  logic par_bit;
  logic [7:0] masked;

  assign step = tick && (sub_reg == 4'(OVS - 1));
  assign busy = (state_reg != asp_pkg::ST_IDLE);
  assign has_extra = mp_mode || (par_sel != asp_pkg::PAR_NONE);
  assign masked = eight_bit ? data : {1'b0, data[6:0]};

  always_comb begin
    case (par_sel)
      asp_pkg::PAR_ODD: par_bit = ~^masked;
      asp_pkg::PAR_EVEN: par_bit = ^masked;
      default: par_bit = 1'b0;
    endcase
  end

  always_comb begin
    case (state_reg)
      asp_pkg::ST_START: cur_bit = 1'b0;
      asp_pkg::ST_DATA: cur_bit = shift_reg[0];
      asp_pkg::ST_EXTRA: cur_bit = extra_reg;
      default: cur_bit = 1'b1;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst || clr) begin
      state_reg <= asp_pkg::ST_IDLE;
      shift_reg <= asp_pkg::SHIFT_IDLE;
      sub_reg <= '0;
      idx_reg <= '0;
      extra_reg <= 1'b0;
      stop2_reg <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (state_reg == asp_pkg::ST_IDLE) begin
        sub_reg <= '0;
      end else if (tick) begin
        sub_reg <= step ? 4'h0 : sub_reg + 4'h1;
      end
      case (state_reg)
        asp_pkg::ST_IDLE: begin
          if (load) begin
            shift_reg <= data;
            extra_reg <= mp_mode ? mp_bit : par_bit;
            idx_reg <= '0;
            stop2_reg <= two_stop;
            state_reg <= asp_pkg::ST_START;
          end
        end
        asp_pkg::ST_START: begin
          if (step) begin
            state_reg <= asp_pkg::ST_DATA;
          end
        end
        asp_pkg::ST_DATA: begin
          if (step) begin
            shift_reg <= {1'b1, shift_reg[7:1]};
            idx_reg <= idx_reg + 3'h1;
            if (idx_reg == (eight_bit ? 3'h7 : 3'h6)) begin
              state_reg <= has_extra ? asp_pkg::ST_EXTRA : asp_pkg::ST_STOP;
            end
          end
        end
        asp_pkg::ST_EXTRA: begin
          if (step) begin
            state_reg <= asp_pkg::ST_STOP;
          end
        end
        asp_pkg::ST_STOP: begin
          if (step) begin
            // second stop bit on transmit only
            if (stop2_reg) begin
              stop2_reg <= 1'b0;
            end else begin
              state_reg <= asp_pkg::ST_IDLE;
              done <= 1'b1;
            end
          end
        end
        default: state_reg <= asp_pkg::ST_IDLE;
      endcase
    end
  end

  // ir pulse is the first 3/16 of a zero bit
  always_ff @(posedge clk) begin
    if (rst || clr) begin
      // idle level of the mode, else a stray ir pulse follows enable
      line <= !irda;
    end else begin
      line <= irda ? (~cur_bit && (sub_reg < 4'(asp_pkg::IRDA_PULSE))) : cur_bit;
    end
  end

  a_shift_ones: assert property (@(posedge clk) disable iff (rst)
    clr |=> (shift_reg == asp_pkg::SHIFT_IDLE) && !busy)
    else $error("shifter not all ones while stopped");

  a_start_low: assert property (@(posedge clk) disable iff (rst)
    (state_reg == asp_pkg::ST_START) && !irda && !clr |=> !line)
    else $error("start bit not driven low");
endmodule : asp_tx
`default_nettype wire

// >>> core/asp_top.sv
// asynchronous serial port with ir pulse mode: registers, receiver, pin control
`timescale 1ns/1ps
`default_nettype none
module asp_top #(
  parameter int BAUD_DIV = asp_pkg::BAUD_DIV_DEF
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [15:0] bus_addr,
  input wire logic bus_wr,
  input wire logic [7:0] bus_wr_mask,
  input wire logic [7:0] bus_wr_data,
  input wire logic bus_rd,
  output logic [7:0] bus_rd_data,
  input wire logic serial_in_pin,
  output logic serial_out_pin,
  input wire logic irda_mode,
  input wire logic mp_mode,
  input wire logic mp_send_id,
  output logic receive_done_irq,
  output logic receive_error_irq,
  output logic transmit_done_irq
);
  logic [7:0] serial_mode_control_reg;
  logic [7:0] transmit_buffer_reg;
  logic [7:0] receive_buffer_reg;
  logic [3:0] receive_error_status_reg;
  logic tx_buffer_full_flag_reg;
  logic unread_reg;
  logic clock_enable_bit;
  logic transmit_enable_bit;
  logic receive_enable_bit;
  logic char_length_bit;
  logic stop_bits_select;
  logic error_irq_select;
  asp_pkg::asp_par_t par_sel;
  logic tick;
  logic tx_clr;
  logic tx_load;
  logic tx_line;
  logic tx_busy;
  logic tx_done;
  logic [1:0] armed;

  assign clock_enable_bit = serial_mode_control_reg[asp_pkg::MODE_CLK_EN];
  assign transmit_enable_bit = serial_mode_control_reg[asp_pkg::MODE_TX_EN];
  assign receive_enable_bit = serial_mode_control_reg[asp_pkg::MODE_RX_EN];
  assign char_length_bit = serial_mode_control_reg[asp_pkg::MODE_CHAR_LEN];
  assign stop_bits_select = serial_mode_control_reg[asp_pkg::MODE_STOP_SEL];
  assign error_irq_select = serial_mode_control_reg[asp_pkg::MODE_ERR_SEL];
  assign par_sel = asp_pkg::asp_par_t'({serial_mode_control_reg[asp_pkg::MODE_PAR_HI],
                                         serial_mode_control_reg[asp_pkg::MODE_PAR_LO]});

  logic wr_mode;
  logic wr_txbuf;
  logic rd_rxbuf;
  logic rd_err;
  assign wr_mode = bus_wr && (bus_addr == asp_pkg::MODE_ADDR);
  assign wr_txbuf = bus_wr && (bus_addr == asp_pkg::TXBUF_ADDR);
  assign rd_rxbuf = bus_rd && (bus_addr == asp_pkg::RXBUF_ADDR);
  assign rd_err = bus_rd && (bus_addr == asp_pkg::ERR_ADDR);

  // per-bit masked write, reset to zero
  always_ff @(posedge clk) begin
    if (rst) begin
      serial_mode_control_reg <= asp_pkg::MODE_RST;
    end else if (wr_mode) begin
      serial_mode_control_reg <= (serial_mode_control_reg & ~bus_wr_mask) | (bus_wr_data & bus_wr_mask);
    end
  end

  // a stopped divider is the stopped port clock
  asp_baud #(
    .DIV(BAUD_DIV)
  ) u_baud (
    .clk(clk),
    .rst(rst),
    .run(clock_enable_bit),
    .tick(tick)
  );

  // settle count runs on the divider ticks; bit 0 transmit, bit 1 receive
  for (genvar i = 0; i < 2; i++) begin : g_settle
    logic [1:0] cnt_reg;
    logic en;
    assign en = clock_enable_bit && ((i == 0) ? transmit_enable_bit : receive_enable_bit);
    always_ff @(posedge clk) begin
      if (rst || !en) begin
        cnt_reg <= 2'h0;
      end else if (tick && (cnt_reg != 2'(asp_pkg::SETTLE_TICKS))) begin
        cnt_reg <= cnt_reg + 2'h1;
      end
    end
    assign armed[i] = (cnt_reg == 2'(asp_pkg::SETTLE_TICKS));
  end

  // ---------------- transmit side ----------------
  // disable acts as a synchronous reset of the transmitter
  assign tx_clr = !clock_enable_bit || !transmit_enable_bit;
  assign tx_load = tx_buffer_full_flag_reg && !tx_busy && armed[0];

  // buffer resets to ones; only system reset restores it
  always_ff @(posedge clk) begin
    if (rst) begin
      transmit_buffer_reg <= asp_pkg::TXBUF_RST;
    end else if (wr_txbuf && !tx_buffer_full_flag_reg) begin
      transmit_buffer_reg <= bus_wr_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || tx_clr) begin
      tx_buffer_full_flag_reg <= 1'b0;
    end else if (wr_txbuf && !tx_buffer_full_flag_reg) begin
      tx_buffer_full_flag_reg <= 1'b1;
    end else if (tx_load) begin
      tx_buffer_full_flag_reg <= 1'b0;
    end
  end

  asp_tx #(
    .OVS(asp_pkg::OVS)
  ) u_tx (
    .clk(clk),
    .rst(rst),
    .clr(tx_clr),
    .tick(tick),
    .load(tx_load),
    .data(transmit_buffer_reg),
    .eight_bit(char_length_bit),
    .par_sel(par_sel),
    .two_stop(stop_bits_select),
    .mp_mode(mp_mode),
    .mp_bit(mp_send_id),
    .irda(irda_mode),
    .line(tx_line),
    .busy(tx_busy),
    .done(tx_done)
  );

  // output low while the clock is stopped
  always_ff @(posedge clk) begin
    if (rst || !clock_enable_bit) begin
      serial_out_pin <= 1'b0;
    // idle high normally; the tx line idles low in ir mode
    end else if (tx_clr) begin
      serial_out_pin <= !irda_mode;
    end else begin
      serial_out_pin <= tx_line;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      transmit_done_irq <= 1'b0;
    end else begin
      transmit_done_irq <= tx_done;
    end
  end

  // ---------------- receive side ----------------
  logic sync1_reg;
  logic sync2_reg;
  logic [3:0] stretch_reg;
  logic rx_level;
  logic rx_clr;

  always_ff @(posedge clk) begin
    if (rst) begin
      sync1_reg <= 1'b1;
      sync2_reg <= 1'b1;
    end else begin
      sync1_reg <= serial_in_pin;
      sync2_reg <= sync1_reg;
    end
  end

  // a short ir pulse is held as a zero for one bit time
  always_ff @(posedge clk) begin
    if (rst || !irda_mode) begin
      stretch_reg <= 4'h0;
    end else if (sync2_reg) begin
      stretch_reg <= 4'(asp_pkg::OVS - 1);
    end else if (tick && (stretch_reg != 4'h0)) begin
      stretch_reg <= stretch_reg - 4'h1;
    end
  end
  assign rx_level = irda_mode ? !(sync2_reg || (stretch_reg != 4'h0)) : sync2_reg;

  // disable acts as a synchronous reset of the receiver
  assign rx_clr = !clock_enable_bit || !receive_enable_bit;

  asp_pkg::asp_state_t rx_state_reg;
  logic [7:0] receive_shifter_reg;
  logic [3:0] rx_sub_reg;
  logic [2:0] rx_idx_reg;
  logic rx_extra_reg;
  logic rx_step;
  logic rx_fin;
  logic rx_has_extra;
  logic [7:0] rx_word;
  logic par_err;
  logic frame_err;
  logic any_err;

  assign rx_step = tick && (rx_sub_reg == 4'(asp_pkg::OVS - 1));
  assign rx_has_extra = mp_mode || (par_sel != asp_pkg::PAR_NONE);
  assign rx_fin = rx_step && (rx_state_reg == asp_pkg::ST_STOP);

  // deserialiser; mid-bit sampling from the start edge
  always_ff @(posedge clk) begin
    if (rst || rx_clr) begin
      rx_state_reg <= asp_pkg::ST_IDLE;
      receive_shifter_reg <= 8'hff;
      rx_sub_reg <= 4'h0;
      rx_idx_reg <= 3'h0;
      rx_extra_reg <= 1'b0;
    end else begin
      if (rx_state_reg == asp_pkg::ST_IDLE) begin
        rx_sub_reg <= 4'h0;
      end else if (tick) begin
        rx_sub_reg <= rx_step ? 4'h0 : rx_sub_reg + 4'h1;
      end
      case (rx_state_reg)
        asp_pkg::ST_IDLE: begin
          // no reception until two port clocks after enable
          if (armed[1] && !rx_level) begin
            rx_state_reg <= asp_pkg::ST_START;
          end
        end
        asp_pkg::ST_START: begin
          if (tick && (rx_sub_reg == 4'(asp_pkg::SAMPLE_MID - 1))) begin
            rx_sub_reg <= 4'h0;
            rx_idx_reg <= 3'h0;
            rx_state_reg <= rx_level ? asp_pkg::ST_IDLE : asp_pkg::ST_DATA;
          end
        end
        asp_pkg::ST_DATA: begin
          if (rx_step) begin
            receive_shifter_reg <= {rx_level, receive_shifter_reg[7:1]};
            rx_idx_reg <= rx_idx_reg + 3'h1;
            if (rx_idx_reg == (char_length_bit ? 3'h7 : 3'h6)) begin
              rx_state_reg <= rx_has_extra ? asp_pkg::ST_EXTRA : asp_pkg::ST_STOP;
            end
          end
        end
        asp_pkg::ST_EXTRA: begin
          if (rx_step) begin
            rx_extra_reg <= rx_level;
            rx_state_reg <= asp_pkg::ST_STOP;
          end
        end
        // one stop bit checked on receive
        asp_pkg::ST_STOP: begin
          if (rx_step) begin
            rx_state_reg <= asp_pkg::ST_IDLE;
          end
        end
        default: rx_state_reg <= asp_pkg::ST_IDLE;
      endcase
    end
  end

  // seven-bit data right aligned, top bit zero
  assign rx_word = char_length_bit ? receive_shifter_reg : {1'b0, receive_shifter_reg[7:1]};

  // parity check; zero parity never checked
  always_comb begin
    case (par_sel)
      asp_pkg::PAR_ODD: par_err = !mp_mode && ((^rx_word ^ rx_extra_reg) == 1'b0);
      asp_pkg::PAR_EVEN: par_err = !mp_mode && ((^rx_word ^ rx_extra_reg) == 1'b1);
      default: par_err = 1'b0;
    endcase
  end
  assign frame_err = !rx_level;
  assign any_err = par_err || frame_err || unread_reg;

  // buffer back to ones on reset or clock disable
  always_ff @(posedge clk) begin
    if (rst || !clock_enable_bit) begin
      receive_buffer_reg <= asp_pkg::RXBUF_RST;
    end else if (rx_fin && !unread_reg) begin
      receive_buffer_reg <= rx_word;
    end
  end

  // new character wins over a read in the same cycle
  always_ff @(posedge clk) begin
    if (rst || !clock_enable_bit) begin
      unread_reg <= 1'b0;
    end else if (rx_fin) begin
      unread_reg <= 1'b1;
    end else if (rd_rxbuf) begin
      unread_reg <= 1'b0;
    end
  end

  // sticky error flags, cleared by read, set wins over clear
  always_ff @(posedge clk) begin
    if (rst || !clock_enable_bit) begin
      receive_error_status_reg <= asp_pkg::ERR_RST[3:0];
    end else begin
      receive_error_status_reg <= (rd_err ? 4'h0 : receive_error_status_reg) |
        ({4{rx_fin}} & {mp_mode && rx_extra_reg, par_err, frame_err, unread_reg});
    end
  end

  // error routing by the select bit
  always_ff @(posedge clk) begin
    if (rst) begin
      receive_done_irq <= 1'b0;
      receive_error_irq <= 1'b0;
    end else begin
      receive_done_irq <= rx_fin && !(any_err && error_irq_select);
      receive_error_irq <= rx_fin && any_err && error_irq_select;
    end
  end

  // ---------------- read port ----------------
  always_ff @(posedge clk) begin
    if (rst || !bus_rd) begin
      bus_rd_data <= 8'h00;
    end else begin
      case (bus_addr)
        asp_pkg::MODE_ADDR: bus_rd_data <= serial_mode_control_reg;
        asp_pkg::RXBUF_ADDR: bus_rd_data <= receive_buffer_reg;
        asp_pkg::ERR_ADDR: bus_rd_data <= {4'h0, receive_error_status_reg};
        asp_pkg::TXST_ADDR: bus_rd_data <= {6'h00, tx_buffer_full_flag_reg, tx_busy};
        default: bus_rd_data <= 8'h00;
      endcase
    end
  end

  a_txbuf_hold: assert property (@(posedge clk) disable iff (rst)
    wr_txbuf && tx_buffer_full_flag_reg |=> $stable(transmit_buffer_reg))
    else $error("transmit buffer changed while full");

  a_rxbuf_seven: assert property (@(posedge clk) disable iff (rst)
    rx_fin && !unread_reg && !char_length_bit && clock_enable_bit |=> !receive_buffer_reg[7])
    else $error("seven-bit character has top bit set");

  a_overrun_keep: assert property (@(posedge clk) disable iff (rst)
    rx_fin && unread_reg && clock_enable_bit |=> $stable(receive_buffer_reg) && receive_error_status_reg[0])
    else $error("overrun character not discarded");

  a_rxbuf_init: assert property (@(posedge clk) disable iff (rst)
    !clock_enable_bit |=> (receive_buffer_reg == asp_pkg::RXBUF_RST) && !unread_reg)
    else $error("receive buffer not ones while clock stopped");

  a_mode_reset: assert property (@(posedge clk)
    rst |=> (serial_mode_control_reg == asp_pkg::MODE_RST))
    else $error("mode register not cleared by reset");

  a_pin_off_low: assert property (@(posedge clk) disable iff (rst)
    !clock_enable_bit [*2] |-> !serial_out_pin)
    else $error("output not low while clock stopped");

  a_rx_stop: assert property (@(posedge clk) disable iff (rst)
    !receive_enable_bit |=> (rx_state_reg == asp_pkg::ST_IDLE) && !rx_fin)
    else $error("receiver runs while disabled");

  a_zero_par: assert property (@(posedge clk) disable iff (rst)
    rx_fin && (par_sel == asp_pkg::PAR_ZERO) && !rd_err |=> !$rose(receive_error_status_reg[2]))
    else $error("parity error flagged with zero parity");

  a_err_route: assert property (@(posedge clk) disable iff (rst)
    rx_fin && any_err |=> (receive_error_irq == $past(error_irq_select)) && (receive_done_irq != receive_error_irq))
    else $error("receive error routed to wrong pulse");
endmodule : asp_top
`default_nettype wire

// >>> verification/asp_remote.sv
// remote serial device model: sends and captures characters
`timescale 1ns/1ps
`default_nettype none
module asp_remote #(
  parameter int BT = 16
) (
  input wire logic clk,
  input wire logic line_in,
  output logic line_out
);
  initial line_out = 1'b1;
  task automatic send_char(input logic [8:0] d, input int n);
    line_out = 1'b0;
    repeat (BT) @(negedge clk);
    for (int i = 0; i < n; i++) begin
      line_out = d[i];
      repeat (BT) @(negedge clk);
    end
    line_out = 1'b1;
    repeat (BT) @(negedge clk);
  endtask : send_char
  // mid-bit sampling
  // f: start, data lsb first, parity, stop; parity stays 1 if absent
  task automatic get_char(input bit par_en, output logic [10:0] f, output bit found);
    int w;
    f = '1;
    found = 1'b0;
    w = 0;
    while (line_in !== 1'b0 && w < 40 * BT) begin
      @(posedge clk);
      w++;
    end
    if (line_in !== 1'b0) return;
    found = 1'b1;
    repeat (BT / 2) @(posedge clk);
    f[0] = line_in;
    for (int k = 1; k < 11; k++) begin
      if (k == 9 && !par_en) continue;
      repeat (BT) @(posedge clk);
      f[k] = line_in;
    end
  endtask : get_char
endmodule : asp_remote
`default_nettype wire

// >>> verification/tb_top.sv
// self-checking bench for the serial port
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int BT = 16;
  localparam logic [15:0] MA = asp_pkg::MODE_ADDR;
  localparam logic [15:0] TA = asp_pkg::TXBUF_ADDR;
  localparam logic [15:0] RA = asp_pkg::RXBUF_ADDR;
  localparam logic [15:0] EA = asp_pkg::ERR_ADDR;
  localparam logic [15:0] SA = asp_pkg::TXST_ADDR;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [15:0] bus_addr = 16'h0000;
  logic bus_wr = 1'b0;
  logic bus_rd = 1'b0;
  logic [7:0] bus_wr_data = 8'h00;
  logic [7:0] bus_wr_mask = 8'hff;
  logic irda_mode = 1'b0;
  logic mp_mode = 1'b0;
  logic mp_send_id = 1'b0;
  logic rx_done_irq;
  logic rx_err_irq;
  logic tx_done_irq;
  int n_rxd = 0;
  int n_rxe = 0;
  int n_txd = 0;
  int n_hi = 0;
  logic [7:0] bus_rd_data;
  logic serial_in_pin;
  logic serial_out_pin;
  int err_count = 0;
  int comparisons = 0;
  always #5 clk = ~clk;
  // pulse and pin-high counters; scenarios compare differences
  always @(posedge clk) begin
    if (rx_done_irq === 1'b1) n_rxd++;
    if (rx_err_irq === 1'b1) n_rxe++;
    if (tx_done_irq === 1'b1) n_txd++;
    if (serial_out_pin === 1'b1) n_hi++;
  end
  asp_top #(.BAUD_DIV(1)) i_dut (.clk(clk), .rst(rst), .bus_addr(bus_addr), .bus_wr(bus_wr),
    .bus_wr_mask(bus_wr_mask), .bus_wr_data(bus_wr_data), .bus_rd(bus_rd), .bus_rd_data(bus_rd_data),
    .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin), .irda_mode(irda_mode),
    .mp_mode(mp_mode), .mp_send_id(mp_send_id), .receive_done_irq(rx_done_irq),
    .receive_error_irq(rx_err_irq), .transmit_done_irq(tx_done_irq));
  asp_remote #(.BT(BT)) i_rem (.clk(clk), .line_in(serial_out_pin), .line_out(serial_in_pin));
  task automatic chk(input string w, input logic [10:0] seen, input logic [10:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", w, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    bus_addr = a;
    bus_wr_data = d;
    bus_wr = 1'b1;
    @(negedge clk);
    bus_wr = 1'b0;
    @(negedge clk);
  endtask : wr
  task automatic rchk(input string w, input logic [15:0] a, input logic [7:0] e);
    bus_addr = a;
    bus_rd = 1'b1;
    @(negedge clk);
    bus_rd = 1'b0;
    chk(w, {3'h0, bus_rd_data}, {3'h0, e});
    @(negedge clk);
  endtask : rchk
  task automatic t_reset();
    rchk("mode", MA, 8'h00);
    rchk("rx buffer", RA, 8'hff);
    rchk("tx status", SA, 8'h00);
    rchk("unmapped", 16'hff91, 8'h00);
    bus_wr_mask = 8'h01;
    wr(MA, 8'hff);
    rchk("mode bit", MA, 8'h01);
    bus_wr_mask = 8'hff;
    wr(MA, 8'h00);
    chk("pin off", {10'h0, serial_out_pin}, 11'h0);
  endtask : t_reset
  task automatic t_tx();
    logic [10:0] f;
    bit ok;
    logic pb;
    int t;
    for (int p = 0; p < 4; p++) begin
      pb = (p == 0 || p == 2);
      wr(MA, 8'h80);
      wr(MA, 8'hc4 | {3'h0, p[1:0], 3'h0});
      repeat (4) @(negedge clk);
      chk("pin idle", {10'h0, serial_out_pin}, 11'h1);
      t = n_txd;
      fork
        begin
          i_rem.get_char(p != 0, f, ok);
          chk("frame a", f, {1'b1, pb, 8'ha5, 1'b0});
          i_rem.get_char(p != 0, f, ok);
          chk("frame b", f, {1'b1, pb, 8'h3c, 1'b0});
          i_rem.get_char(p != 0, f, ok);
          chk("extra char", {10'h0, ok}, 11'h0);
        end
        begin
          wr(TA, 8'ha5);
          repeat (4) @(negedge clk);
          wr(TA, 8'h3c);
          rchk("full", SA, 8'h03);
          wr(TA, 8'h77);
        end
      join
      chk("tx done", 11'(n_txd - t), 11'h2);
    end
    // drop transmit enable in mid-character
    wr(TA, 8'h00);
    repeat (3 * BT) @(negedge clk);
    wr(MA, 8'h80);
    chk("pin stop", {10'h0, serial_out_pin}, 11'h1);
    rchk("tx cleared", SA, 8'h00);
  endtask : t_tx
  task automatic t_rx();
    int d;
    int e;
    wr(MA, 8'ha4);
    repeat (4) @(negedge clk);
    i_rem.send_char(9'h05a, 8);
    rchk("rx 8 bit", RA, 8'h5a);
    rchk("no error", EA, 8'h00);
    for (int p = 3; p > 0; p -= 2) begin
      wr(MA, 8'h80);
      wr(MA, 8'ha5 | {3'h0, p[1:0], 3'h0});
      repeat (4) @(negedge clk);
      d = n_rxd;
      e = n_rxe;
      i_rem.send_char(9'h1a5, 9);
      chk("done irq", 11'(n_rxd - d), (p == 3) ? 11'h0 : 11'h1);
      chk("error irq", 11'(n_rxe - e), (p == 3) ? 11'h1 : 11'h0);
      rchk("rx parity data", RA, 8'ha5);
      rchk("parity flag", EA, (p == 3) ? 8'h04 : 8'h00);
    end
    wr(MA, 8'h80);
    wr(MA, 8'ha0);
    repeat (4) @(negedge clk);
    i_rem.send_char(9'h0ff, 7);
    rchk("rx 7 bit", RA, 8'h7f);
    i_rem.send_char(9'h011, 7);
    i_rem.send_char(9'h022, 7);
    rchk("overrun keep", RA, 8'h11);
    rchk("overrun flag", EA, 8'h01);
    wr(MA, 8'h80);
    repeat (4) @(negedge clk);
    wr(MA, 8'h00);
    rchk("rx buffer off", RA, 8'hff);
    chk("pin off", {10'h0, serial_out_pin}, 11'h0);
  endtask : t_rx
  task automatic t_modes();
    logic [10:0] f;
    bit ok;
    int d;
    int t;
    irda_mode = 1'b1;
    repeat (2) @(negedge clk);
    d = n_hi;
    t = n_txd;
    wr(MA, 8'hc4);
    repeat (4) @(negedge clk);
    chk("ir idle", {10'h0, serial_out_pin}, 11'h0);
    wr(TA, 8'h0f);
    repeat (12 * BT) @(negedge clk);
    chk("ir pulses", 11'(n_hi - d), 11'(5 * asp_pkg::IRDA_PULSE));
    chk("ir tx done", 11'(n_txd - t), 11'h1);
    wr(MA, 8'h80);
    irda_mode = 1'b0;
    mp_mode = 1'b1;
    mp_send_id = 1'b1;
    wr(MA, 8'hc4);
    repeat (4) @(negedge clk);
    fork
      i_rem.get_char(1'b1, f, ok);
      wr(TA, 8'h5a);
    join
    chk("mp frame", f, {1'b1, 1'b1, 8'h5a, 1'b0});
    repeat (BT) @(negedge clk);
    wr(MA, 8'h80);
    wr(MA, 8'ha4);
    repeat (4) @(negedge clk);
    i_rem.send_char(9'h1c3, 9);
    rchk("mp rx data", RA, 8'hc3);
    rchk("mp id flag", EA, 8'h08);
    wr(MA, 8'h80);
    mp_mode = 1'b0;
    mp_send_id = 1'b0;
  endtask : t_modes
  task automatic end_sim();
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_sim
  initial begin
    repeat (20) @(negedge clk);
    rst = 1'b0;
    t_reset();
    t_tx();
    t_modes();
    t_rx();
    end_sim();
  end
  // about seven times the expected run
  initial begin
    #400us;
    err_count++;
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
